/* File: design/grf_pkg.sv */
package grf_pkg;

  // ------------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------------
  localparam int unsigned XLEN = 32;       // Register width
  localparam int unsigned NUM_REGS = 16;   // General registers
  localparam int unsigned IDX_W = 4;       // Register number width
  localparam int unsigned NUM_BANKS = 5;   // Stack holding registers
  localparam int unsigned BANK_W = 3;      // Holding register select width
  localparam int unsigned NUM_STR = 6;     // Registers open to string state
  localparam int unsigned LEN_W = 5;       // Item length field, up to 31 bytes

  // ------------------------------------------------------------------
  // Register numbers with fixed roles
  // ------------------------------------------------------------------
  localparam logic [IDX_W-1:0] REG_INSTR_ADDR = 4'hf;  // Instruction address
  localparam logic [IDX_W-1:0] REG_STACK_TOP = 4'he;   // Live stack pointer
  localparam logic [IDX_W-1:0] REG_FRAME_BASE = 4'hd;  // Frame pointer
  localparam logic [IDX_W-1:0] REG_ARG_LIST = 4'hc;    // Argument list pointer
  localparam logic [IDX_W-1:0] REG_FREE_FIRST = 4'h6;  // First free register
  localparam logic [IDX_W-1:0] REG_FREE_LAST = 4'hb;   // Last free register
  localparam logic [IDX_W-1:0] REG_STR_LAST = 4'h5;    // Last string register

  // ------------------------------------------------------------------
  // Status longword fields
  // ------------------------------------------------------------------
  localparam int unsigned MODE_LSB = 24;   // Current mode, low bit
  localparam int unsigned MODE_MSB = 25;   // Current mode, high bit
  localparam int unsigned IS_BIT = 26;     // Interrupt stack flag

  // ------------------------------------------------------------------
  // Reset values and bank codes
  // ------------------------------------------------------------------
  localparam logic [XLEN-1:0] RESET_WORD = 32'h0;       // Every register
  localparam logic [BANK_W-1:0] BANK_INTR = 3'h4;       // Shared interrupt stack
  localparam logic [BANK_W-1:0] BANK_LAST_PROC = 3'h3;  // Last per-process bank

  typedef enum logic [1:0] {
    MODE_KERNEL,
    MODE_EXEC,
    MODE_SUPER,
    MODE_USER
  } grf_mode_e;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic en;                // Write strobe
    logic [IDX_W-1:0] idx;   // Register number
    logic [XLEN-1:0] data;   // Write data
  } grf_wr_s;

  typedef struct packed {
    logic en;                // Load strobe
    logic [XLEN-1:0] data;   // Load value
  } grf_ld_s;

  typedef struct packed {
    logic push;              // Push one item
    logic pop;               // Pop one item
    logic [LEN_W-1:0] len;   // Item length in bytes
  } grf_stk_s;

  typedef struct packed {
    logic [NUM_STR-1:0] en;              // Per-register strobe, R0 upward
    logic [NUM_STR-1:0][XLEN-1:0] data;  // Per-register data
  } grf_str_s;

  typedef struct packed {
    logic en;                // New status longword valid
    logic [XLEN-1:0] word;   // Status longword
  } grf_psl_s;

  typedef struct packed {
    logic en;                  // Context write strobe
    logic [BANK_W-1:0] sel;    // Holding register
    logic [XLEN-1:0] data;     // Value
  } grf_bank_wr_s;

endpackage

/* File: design/grf_register_file.sv */
// Notes on behaviour
// - Sixteen registers, selected by number only
// - Register 15 is the instruction address
// - Register 14 is the implicit stack pointer
// - Register 13 frame pointer, loaded on call/return
// - Register 12 argument pointer, loaded on call/return
// - R0 to R5 take interruptible instruction state
// - R0 takes polynomial/checksum result, length counter
// - R1 takes double polynomial result, address counter
// - R2,R4 length counters; R3,R5 address counters
// - R6 to R11 change only on explicit writes
// - Push decrements pointer, then stores there
// - Pop adds length after last use
// - Sequencer stack accesses always go through R14
// - Five holding registers, one live by mode
// - On mode change save old, load new
// - Interrupt stack shared, others per process
// - Mode is bits 25:24, kernel to user
// - Bit 26 selects interrupt stack, forces kernel
module grf_register_file (
  input wire logic i_clk,                               // Processor clock
  input wire logic i_rst_n,                             // Async reset, low
  input wire logic [grf_pkg::IDX_W-1:0] i_rd_a_idx,     // Read port A number
  output logic [grf_pkg::XLEN-1:0] o_rd_a_data,         // Read port A data
  input wire logic [grf_pkg::IDX_W-1:0] i_rd_b_idx,     // Read port B number
  output logic [grf_pkg::XLEN-1:0] o_rd_b_data,         // Read port B data
  input wire grf_pkg::grf_wr_s i_wr,                    // Explicit operand write
  input wire grf_pkg::grf_ld_s i_instr_addr_ld,         // Instruction address update
  input wire grf_pkg::grf_stk_s i_stk,                  // Implicit push or pop
  input wire grf_pkg::grf_ld_s i_frame_ld,              // Frame pointer load
  input wire grf_pkg::grf_ld_s i_arg_ld,                // Argument pointer load
  input wire grf_pkg::grf_str_s i_str,                  // String/decimal/result state
  input wire grf_pkg::grf_psl_s i_psl,                  // New status longword
  input wire grf_pkg::grf_bank_wr_s i_ctx_wr,           // Context stack write
  input wire logic [grf_pkg::BANK_W-1:0] i_ctx_rd_sel,  // Context stack read select
  output logic [grf_pkg::XLEN-1:0] o_ctx_rd_data,       // Context stack read data
  output logic [grf_pkg::XLEN-1:0] o_instr_addr,        // Live instruction address
  output logic [grf_pkg::XLEN-1:0] o_stack_top,         // Live stack pointer
  output logic [grf_pkg::XLEN-1:0] o_stack_access_addr, // Address of this stack access
  output grf_pkg::grf_mode_e o_cur_mode,                // Current access mode
  output logic o_interrupt_stack_flag,                  // Interrupt stack in use
  output logic [grf_pkg::BANK_W-1:0] o_bank_sel         // Live holding register
);

  // ------------------------------------------------------------------
  // Storage and selection state
  // ------------------------------------------------------------------
  logic [grf_pkg::XLEN-1:0] gpr_reg [grf_pkg::NUM_REGS];    // General registers
  grf_pkg::grf_mode_e mode_reg;                             // Current mode
  grf_pkg::grf_mode_e mode_next;                            // Mode after update
  logic is_reg;                                             // Interrupt stack flag
  logic is_next;                                            // Flag after update
  logic [grf_pkg::BANK_W-1:0] bank_sel;                     // Old selection
  logic [grf_pkg::BANK_W-1:0] bank_sel_next;                // New selection
  logic swap;                                               // Stack pointer swap
  logic [grf_pkg::XLEN-1:0] tos_adj;                        // Pointer after push/pop
  logic tos_change;                                         // Push or pop requested
  logic [grf_pkg::XLEN-1:0] bank_load;                      // Pointer for new mode
  logic [grf_pkg::NUM_REGS-1:0] impl_en;                    // Implicit update strobes
  logic [grf_pkg::XLEN-1:0] impl_data [grf_pkg::NUM_REGS];  // Implicit update data

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------

  // Pick mode and flag out of the new longword; flag forces kernel
  always_comb
  begin
    mode_next = mode_reg;
    is_next = is_reg;
    if (i_psl.en)
    begin
      is_next = i_psl.word[grf_pkg::IS_BIT];
      if (i_psl.word[grf_pkg::IS_BIT])
      begin
        mode_next = grf_pkg::MODE_KERNEL;
      end
      else
      begin
        // Two-bit field, all four codes legal
        mode_next = grf_pkg::grf_mode_e'(
          i_psl.word[grf_pkg::MODE_MSB:grf_pkg::MODE_LSB]);
      end
    end
  end

  // Holding register selection for old and new values
  always_comb
  begin
    bank_sel = is_reg ? grf_pkg::BANK_INTR
                      : {1'b0, mode_reg};
    bank_sel_next = is_next ? grf_pkg::BANK_INTR
                            : {1'b0, mode_next};
    // Only a real change of selection swaps; rewriting equal values is a no-op
    swap = i_psl.en && (bank_sel_next != bank_sel);
  end

  // Mode and flag registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_reg <= grf_pkg::MODE_KERNEL;
      is_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      is_reg <= is_next;
    end
  end

  // ------------------------------------------------------------------
  // Stack pointer path
  // ------------------------------------------------------------------

  // Push and pop arithmetic on the live pointer in R14
  grf_tos_adjust u_tos_adjust (
    .i_tos (gpr_reg[grf_pkg::REG_STACK_TOP]),
    .i_stk (i_stk),
    .o_tos_next (tos_adj),
    .o_change (tos_change)
  );

  // Saved value includes any push or pop done in the same cycle
  grf_stack_bank u_stack_bank (
    .i_clk (i_clk),
    .i_rst_n (i_rst_n),
    .i_save_en (swap),
    .i_save_sel (bank_sel),
    .i_save_data (tos_adj),
    .i_load_sel (bank_sel_next),
    .o_load_data (bank_load),
    .i_ctx_wr (i_ctx_wr),
    .i_ctx_rd_sel (i_ctx_rd_sel),
    .o_ctx_rd_data (o_ctx_rd_data)
  );

  // ------------------------------------------------------------------
  // Implicit updates per register
  // ------------------------------------------------------------------
  for (genvar g = 0; g < grf_pkg::NUM_REGS; g++)
  begin : g_impl
    localparam logic [grf_pkg::IDX_W-1:0] IDX = grf_pkg::IDX_W'(g); // This number

    // Each fixed role has its own source; R6..R11 have none
    always_comb
    begin
      impl_en[g] = 1'b0;
      impl_data[g] = grf_pkg::RESET_WORD;
      if (IDX == grf_pkg::REG_INSTR_ADDR)
      begin
        impl_en[g] = i_instr_addr_ld.en;
        impl_data[g] = i_instr_addr_ld.data;
      end
      else if (IDX == grf_pkg::REG_STACK_TOP)
      begin
        // Swap load beats push/pop; the adjusted value went to the old bank
        if (swap)
        begin
          impl_en[g] = 1'b1;
          impl_data[g] = bank_load;
        end
        else
        begin
          impl_en[g] = tos_change;
          impl_data[g] = tos_adj;
        end
      end
      else if (IDX == grf_pkg::REG_FRAME_BASE)
      begin
        impl_en[g] = i_frame_ld.en;
        impl_data[g] = i_frame_ld.data;
      end
      else if (IDX == grf_pkg::REG_ARG_LIST)
      begin
        impl_en[g] = i_arg_ld.en;
        impl_data[g] = i_arg_ld.data;
      end
      else if (IDX <= grf_pkg::REG_STR_LAST)
      begin
        // R0/R1 results, even registers lengths, odd ones addresses
        impl_en[g] = i_str.en[g % grf_pkg::NUM_STR];
        impl_data[g] = i_str.data[g % grf_pkg::NUM_STR];
      end
      else if (IDX >= grf_pkg::REG_FREE_FIRST && IDX <= grf_pkg::REG_FREE_LAST)
      begin
        // No hardware source: stays as explicitly written
        impl_en[g] = 1'b0;
      end
    end

    // Storage: implicit update wins over the operand write
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        gpr_reg[g] <= grf_pkg::RESET_WORD;
      end
      else if (impl_en[g])
      begin
        gpr_reg[g] <= impl_data[g];
      end
      else if (i_wr.en && i_wr.idx == IDX)
      begin
        gpr_reg[g] <= i_wr.data;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read side
  // ------------------------------------------------------------------

  // Two combinational read ports by register number
  always_comb
  begin
    o_rd_a_data = gpr_reg[i_rd_a_idx];
    o_rd_b_data = gpr_reg[i_rd_b_idx];
  end

  // Live views of fixed-role registers and mode state
  always_comb
  begin
    o_instr_addr = gpr_reg[grf_pkg::REG_INSTR_ADDR];
    o_stack_top = gpr_reg[grf_pkg::REG_STACK_TOP];
    // Push stores at the decremented pointer; pop reads at the current one
    o_stack_access_addr = i_stk.push ? tos_adj
                                     : gpr_reg[grf_pkg::REG_STACK_TOP];
    o_cur_mode = mode_reg;
    o_interrupt_stack_flag = is_reg;
    o_bank_sel = bank_sel;
  end

endmodule

/* File: design/grf_sp_adjust.sv */
// ------------------------------------------------------------------
// Stack pointer arithmetic for push and pop
// ------------------------------------------------------------------
module grf_tos_adjust (
  input wire logic [grf_pkg::XLEN-1:0] i_tos,      // Live stack pointer
  input wire grf_pkg::grf_stk_s i_stk,             // Push or pop request
  output logic [grf_pkg::XLEN-1:0] o_tos_next,     // Adjusted stack pointer
  output logic o_change                            // Adjustment requested
);

  logic [grf_pkg::XLEN-1:0] len_w; // Length widened to a word

  // Push decrements first, pop adds after last use of the item
  always_comb
  begin
    len_w = {{(grf_pkg::XLEN-grf_pkg::LEN_W){1'b0}}, i_stk.len};
    o_change = i_stk.push | i_stk.pop;
    if (i_stk.push && !i_stk.pop)
    begin
      o_tos_next = i_tos - len_w;
    end
    else if (i_stk.pop && !i_stk.push)
    begin
      o_tos_next = i_tos + len_w;
    end
    else
    begin
      // Both or neither: pop and push of one length cancel
      o_tos_next = i_tos;
    end
  end

endmodule

/* File: design/grf_stack_bank.sv */
// ------------------------------------------------------------------
// Five stack holding registers
// ------------------------------------------------------------------
module grf_stack_bank (
  input wire logic i_clk,                                 // Processor clock
  input wire logic i_rst_n,                               // Async reset, low
  input wire logic i_save_en,                             // Save live pointer
  input wire logic [grf_pkg::BANK_W-1:0] i_save_sel,      // Bank for the save
  input wire logic [grf_pkg::XLEN-1:0] i_save_data,       // Live pointer value
  input wire logic [grf_pkg::BANK_W-1:0] i_load_sel,      // Bank to load from
  output logic [grf_pkg::XLEN-1:0] o_load_data,           // Value to load
  input wire grf_pkg::grf_bank_wr_s i_ctx_wr,             // Context write
  input wire logic [grf_pkg::BANK_W-1:0] i_ctx_rd_sel,    // Context read select
  output logic [grf_pkg::XLEN-1:0] o_ctx_rd_data          // Context read data
);

  logic [grf_pkg::XLEN-1:0] hold_reg [grf_pkg::NUM_BANKS]; // Holding registers

  // ------------------------------------------------------------------
  // One holding register per mode plus the interrupt stack
  // ------------------------------------------------------------------
  for (genvar g = 0; g < grf_pkg::NUM_BANKS; g++)
  begin : g_hold
    // Swap save beats a context write; only per-process banks are in context
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        hold_reg[g] <= grf_pkg::RESET_WORD;
      end
      else if (i_save_en && i_save_sel == grf_pkg::BANK_W'(g))
      begin
        hold_reg[g] <= i_save_data;
      end
      else if (i_ctx_wr.en && i_ctx_wr.sel == grf_pkg::BANK_W'(g)
               && i_ctx_wr.sel <= grf_pkg::BANK_LAST_PROC)
      begin
        hold_reg[g] <= i_ctx_wr.data;
      end
    end
  end

  // Reads; an out-of-range select reads zero
  always_comb
  begin
    o_load_data = grf_pkg::RESET_WORD;
    o_ctx_rd_data = grf_pkg::RESET_WORD;
    if (i_load_sel <= grf_pkg::BANK_INTR)
    begin
      o_load_data = hold_reg[i_load_sel];
    end
    if (i_ctx_rd_sel <= grf_pkg::BANK_INTR)
    begin
      o_ctx_rd_data = hold_reg[i_ctx_rd_sel];
    end
  end

endmodule

/* File: verif/grf_exec_model.sv */
// ------------------------------------------------------------------
// Execution datapath stand-in: one-cycle strobes
// ------------------------------------------------------------------
module grf_exec_model (
  input wire logic i_clk,            // Processor clock
  output grf_pkg::grf_wr_s o_wr,     // Explicit operand write
  output grf_pkg::grf_ld_s o_ia,     // Instruction address load
  output grf_pkg::grf_stk_s o_stk,   // Push or pop
  output grf_pkg::grf_ld_s o_fr,     // Frame pointer load
  output grf_pkg::grf_ld_s o_ar,     // Argument pointer load
  output grf_pkg::grf_str_s o_str,   // Interruptible instruction state
  output grf_pkg::grf_psl_s o_psl,   // New status longword
  output grf_pkg::grf_bank_wr_s o_ctx // Context stack write
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle everything; strobes never linger past one edge
  task automatic clear();
    o_wr = '0;
    o_ia = '0;
    o_stk = '0;
    o_fr = '0;
    o_ar = '0;
    o_str = '0;
    o_psl = '0;
    o_ctx = '0;
  endtask
  initial clear();
  // Request setters, called just after a falling edge
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    o_wr = {1'b1, idx, d};
  endtask
  task automatic ld(input int k, input logic [31:0] d);
    if (k == 0) o_ia = {1'b1, d};
    else if (k == 1) o_fr = {1'b1, d};
    else o_ar = {1'b1, d};
  endtask
  task automatic stk(input logic pu, input logic po, input logic [4:0] len);
    o_stk = {pu, po, len};
  endtask
  task automatic str(input int n, input logic [31:0] d);
    o_str.en[n] = 1'b1;
    o_str.data[n] = d;
  endtask
  task automatic psl(input logic [31:0] w);
    o_psl = {1'b1, w};
  endtask
  task automatic ctx(input logic [2:0] s, input logic [31:0] d);
    o_ctx = {1'b1, s, d};
  endtask
  // One rising edge takes the request, then drop it
  task automatic step();
    @(posedge i_clk);
    @(negedge i_clk);
    clear();
    #1;
  endtask
endmodule

/* File: verif/grf_register_file_assertions.sv */
// ------------------------------------------------------------------
// Port-level checks on the register file
// ------------------------------------------------------------------
module grf_register_file_checker (
  input wire logic i_clk,                               // Processor clock
  input wire logic i_rst_n,                             // Async reset, low
  input wire logic [grf_pkg::IDX_W-1:0] i_rd_a_idx,     // Read port A number
  input wire logic [grf_pkg::XLEN-1:0] o_rd_a_data,     // Read port A data
  input wire grf_pkg::grf_wr_s i_wr,                    // Explicit write
  input wire grf_pkg::grf_ld_s i_instr_addr_ld,         // Instruction address load
  input wire grf_pkg::grf_stk_s i_stk,                  // Push or pop
  input wire grf_pkg::grf_ld_s i_frame_ld,              // Frame pointer load
  input wire grf_pkg::grf_str_s i_str,                  // String state writes
  input wire grf_pkg::grf_psl_s i_psl,                  // New status longword
  input wire grf_pkg::grf_bank_wr_s i_ctx_wr,           // Context write
  input wire logic [grf_pkg::BANK_W-1:0] i_ctx_rd_sel,  // Context read select
  input wire logic [grf_pkg::XLEN-1:0] o_ctx_rd_data,   // Context read data
  input wire logic [grf_pkg::XLEN-1:0] o_instr_addr,    // Instruction address
  input wire logic [grf_pkg::XLEN-1:0] o_stack_top,     // Live stack pointer
  input wire logic [grf_pkg::XLEN-1:0] o_stack_access_addr, // Stack access address
  input wire grf_pkg::grf_mode_e o_cur_mode,            // Current mode
  input wire logic o_interrupt_stack_flag,              // Interrupt stack flag
  input wire logic [grf_pkg::BANK_W-1:0] o_bank_sel     // Live holding register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic [2:0] new_sel; // Bank the incoming status word asks for
  assign new_sel = i_psl.word[26] ? 3'h4 : {1'b0, i_psl.word[25:24]};

  push_addr_a: assert property (i_stk.push && !i_stk.pop |->
    o_stack_access_addr == o_stack_top - {27'h0, i_stk.len}) else $error("push address wrong");
  push_dec_a: assert property (i_stk.push && !i_stk.pop && !i_psl.en |=>
    o_stack_top == $past(o_stack_top) - {27'h0, $past(i_stk.len)}) else $error("push no dec");
  pop_inc_a: assert property (i_stk.pop && !i_stk.push && !i_psl.en |=>
    o_stack_top == $past(o_stack_top) + {27'h0, $past(i_stk.len)}) else $error("pop no inc");
  instr_load_a: assert property (i_instr_addr_ld.en |=>
    o_instr_addr == $past(i_instr_addr_ld.data)) else $error("instr address not loaded");
  frame_load_a: assert property (i_frame_ld.en ##1 i_rd_a_idx == 4'hd |->
    o_rd_a_data == $past(i_frame_ld.data)) else $error("frame pointer not loaded");
  implicit_wins_a: assert property (i_str.en[0] && i_wr.en && i_wr.idx == 4'h0
    ##1 i_rd_a_idx == 4'h0 |-> o_rd_a_data == $past(i_str.data[0])) else $error("priority");
  free_hold_a: assert property ((i_rd_a_idx inside {[4'h6:4'hb]} &&
    !(i_wr.en && i_wr.idx == i_rd_a_idx)) ##1 i_rd_a_idx == $past(i_rd_a_idx)
    |-> o_rd_a_data == $past(o_rd_a_data)) else $error("free register changed");
  intr_kernel_a: assert property (o_interrupt_stack_flag |->
    o_cur_mode == grf_pkg::MODE_KERNEL && o_bank_sel == grf_pkg::BANK_INTR) else $error("is");
  mode_bank_a: assert property (!o_interrupt_stack_flag |->
    o_bank_sel == {1'b0, o_cur_mode}) else $error("bank does not follow mode");
  psl_take_a: assert property (i_psl.en |=> o_bank_sel == $past(new_sel))
    else $error("status word not taken");
  swap_load_a: assert property (i_psl.en && new_sel != o_bank_sel &&
    i_ctx_rd_sel == new_sel && !i_ctx_wr.en |=> o_stack_top == $past(o_ctx_rd_data))
    else $error("swap load wrong");
  swap_save_a: assert property ((i_psl.en && new_sel != o_bank_sel && !i_stk.push &&
    !i_stk.pop && !i_ctx_wr.en) ##1 i_ctx_rd_sel == $past(o_bank_sel)
    |-> o_ctx_rd_data == $past(o_stack_top)) else $error("swap save wrong");
endmodule

bind grf_register_file grf_register_file_checker u_chk (.i_clk, .i_rst_n, .i_rd_a_idx,
  .o_rd_a_data, .i_wr, .i_instr_addr_ld, .i_stk, .i_frame_ld, .i_str, .i_psl, .i_ctx_wr,
  .i_ctx_rd_sel, .o_ctx_rd_data, .o_instr_addr, .o_stack_top, .o_stack_access_addr,
  .o_cur_mode, .o_interrupt_stack_flag, .o_bank_sel);

/* File: verif/tb_grf_register_file.sv */
module tb_grf_register_file;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] idx;
    logic [31:0] data;
    logic [31:0] exp;
  } grf_row_s;
  logic i_clk, i_rst_n; // Clock, reset
  logic [3:0] i_rd_a_idx, i_rd_b_idx; // Read numbers
  logic [2:0] i_ctx_rd_sel, o_bank_sel, sel_exp, nsel; // Bank selects
  logic [31:0] o_rd_a_data, o_rd_b_data, o_ctx_rd_data, o_instr_addr, o_stack_top, o_saddr;
  logic [31:0] tos_exp, w; // Expected pointer, status word
  logic [31:0] bank_exp [5]; // Expected holding registers
  grf_pkg::grf_mode_e o_cur_mode; // Mode out
  logic o_interrupt_stack_flag; // Flag out
  grf_pkg::grf_wr_s wr;
  grf_pkg::grf_ld_s ia, fr, ar;
  grf_pkg::grf_stk_s stk;
  grf_pkg::grf_str_s str;
  grf_pkg::grf_psl_s psl;
  grf_pkg::grf_bank_wr_s ctx;
  grf_row_s rows [8]; // Explicit writes and the read-back they give
  logic [31:0] words [6]; // Status words, every mode and the flag
  int fails, samples_checked;

  grf_exec_model mdl (.i_clk, .o_wr(wr), .o_ia(ia), .o_stk(stk), .o_fr(fr), .o_ar(ar),
    .o_str(str), .o_psl(psl), .o_ctx(ctx));
  grf_register_file uut (.i_clk, .i_rst_n, .i_rd_a_idx, .o_rd_a_data, .i_rd_b_idx, .o_rd_b_data,
    .i_wr(wr), .i_instr_addr_ld(ia), .i_stk(stk), .i_frame_ld(fr), .i_arg_ld(ar), .i_str(str),
    .i_psl(psl), .i_ctx_wr(ctx), .i_ctx_rd_sel, .o_ctx_rd_data, .o_instr_addr, .o_stack_top,
    .o_stack_access_addr(o_saddr), .o_cur_mode, .o_interrupt_stack_flag, .o_bank_sel);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Both ports read the same register, so each port is exercised
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    i_rd_a_idx = idx;
    i_rd_b_idx = idx;
    #1;
    check(o_rd_a_data, exp);
    check(o_rd_b_data, exp);
  endtask
  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Run is about forty cycles; this limit only trips on a hang
  initial
  begin
    repeat (3000) @(posedge i_clk);
    fails++;
    print_verdict();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    i_rst_n = 1'b0;
    i_rd_a_idx = 4'h0;
    i_rd_b_idx = 4'h0;
    i_ctx_rd_sel = 3'h0;
    fails = 0;
    samples_checked = 0;
    rows = '{'{4'h0, 32'h0000_0011, 32'h0000_0011}, '{4'h5, 32'h0000_0055, 32'h0000_0055},
      '{4'h6, 32'h0000_0066, 32'h0000_0066}, '{4'hb, 32'h0000_00bb, 32'h0000_00bb},
      '{4'hc, 32'h0000_00cc, 32'h0000_00cc}, '{4'hd, 32'h0000_00dd, 32'h0000_00dd},
      '{4'he, 32'h0000_8000, 32'h0000_8000}, '{4'hf, 32'h0000_1000, 32'h0000_1000}};
    words = '{32'h0100_0000, 32'h0300_0000, 32'h0400_0000, 32'h0700_0000, 32'h0200_0000,
      32'h0000_0000};
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    for (int n = 0; n < 16; n++) rd(4'(n), 32'h0);
    for (int n = 0; n < 5; n++)
    begin
      i_ctx_rd_sel = 3'(n);
      #1 check(o_ctx_rd_data, 32'h0);
      bank_exp[n] = 32'h0;
    end
    check({26'h0, o_cur_mode, o_interrupt_stack_flag, o_bank_sel}, 32'h0);
    // Ordinary explicit writes, read back through both ports
    foreach (rows[k])
    begin
      mdl.wr(rows[k].idx, rows[k].data);
      mdl.step();
      rd(rows[k].idx, rows[k].exp);
    end
    // Implicit loads; the second R15 load, the R13 load and the R0 load collide with an explicit write
    mdl.ld(0, 32'h0000_2000);
    mdl.step();
    check(o_instr_addr, 32'h0000_2000);
    mdl.ld(0, 32'h0000_2004);
    mdl.wr(4'hf, 32'hdead_0000);
    mdl.step();
    check(o_instr_addr, 32'h0000_2004);
    mdl.ld(1, 32'h0000_7f00);
    mdl.ld(2, 32'h0000_7e00);
    mdl.wr(4'hd, 32'hdead_0001);
    mdl.step();
    rd(4'hc, 32'h0000_7e00);
    rd(4'hd, 32'h0000_7f00);
    for (int n = 0; n < 6; n++) mdl.str(n, 32'h0000_0a00 + n);
    mdl.wr(4'h0, 32'hdead_0002);
    mdl.step();
    for (int n = 5; n >= 0; n--) rd(4'(n), 32'h0000_0a00 + n);
    // Push address is seen before the edge, pointer moves after it
    mdl.stk(1'b1, 1'b0, 5'h04);
    #1 check(o_saddr, 32'h0000_7ffc);
    mdl.step();
    check(o_stack_top, 32'h0000_7ffc);
    mdl.stk(1'b0, 1'b1, 5'h08);
    mdl.step();
    check(o_stack_top, 32'h0000_8004);
    mdl.stk(1'b1, 1'b1, 5'h10);
    mdl.step();
    check(o_stack_top, 32'h0000_8004);
    // Context writes: executive bank taken, interrupt bank refused
    mdl.ctx(3'h1, 32'h0000_5500);
    mdl.step();
    mdl.ctx(3'h4, 32'hdead_0003);
    mdl.step();
    bank_exp[1] = 32'h0000_5500;
    i_ctx_rd_sel = 3'h4;
    #1 check(o_ctx_rd_data, 32'h0);
    // Walk every mode and the flag, pushing a distinct amount in each
    tos_exp = 32'h0000_8004;
    sel_exp = 3'h0;
    foreach (words[k])
    begin
      w = words[k];
      nsel = w[26] ? 3'h4 : {1'b0, w[25:24]};
      if (nsel != sel_exp)
      begin
        bank_exp[sel_exp] = tos_exp;
        tos_exp = bank_exp[nsel];
      end
      i_ctx_rd_sel = nsel;
      mdl.psl(w);
      mdl.step();
      check(o_stack_top, tos_exp);
      check({26'h0, o_cur_mode, o_interrupt_stack_flag, o_bank_sel},
        {26'h0, (w[26] ? 2'h0 : w[25:24]), w[26], nsel});
      i_ctx_rd_sel = sel_exp;
      #1 check(o_ctx_rd_data, bank_exp[sel_exp]);
      sel_exp = nsel;
      mdl.stk(1'b1, 1'b0, 5'(4 * k + 4));
      mdl.step();
      tos_exp = tos_exp - 32'(4 * k + 4);
    end
    rd(4'h6, 32'h0000_0066);
    repeat (2) mdl.step();
    rd(4'hb, 32'h0000_00bb);
    // Reset again in mid-run
    i_rst_n = 1'b0;
    rd(4'h6, 32'h0);
    check(o_stack_top, 32'h0);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    print_verdict();
  end
endmodule
